/* File: rtl/psm_param_set_mgr.sv */
// parameter set manager: working copy, set load/save, recovery and image selection
// Functional notes
// - one 256-entry volatile working copy feeds every internal function.
// - host parameter reads and writes act on the working copy.
// - non-volatile store keeps set 0 default and set 1 user.
// - default set loads but is never written by host commands.
// - load of set 0 or 1 replaces the whole working copy.
// - save to user set writes the whole working copy there.
// - save to default set is refused with an error code.
// - every power-up loads the user set before normal operation.
// - recovery copies default set over user set, then loads user set.
// - two firmware areas; golden area never changed by host.
// - update area takes section write, section read and whole delete.
// - boot tries the update image first if it is bootable.
// - a failed update image boots the golden image instead.
// - running firmware version is readable by the host.
// - firmware commands accepted from every host interface alike.
// - update delete needs a prior valid service code unlock.
`timescale 1ns/1ps
`default_nettype none
module psm_param_set_mgr (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    default_recovery_input,
  input  wire logic                    req_valid,
  input  wire psm_pkg::psm_req_t       req,
  output logic                         req_ready,
  output logic                         rsp_valid,
  output psm_pkg::psm_rsp_t            rsp,
  output logic                         nv_req,
  output psm_pkg::psm_nv_cmd_t         nv_cmd,
  input  wire logic                    nv_ack,
  input  wire logic [psm_pkg::DW-1:0]  nv_rdata,
  output logic                         fw_req,
  output psm_pkg::psm_fw_cmd_t         fw_cmd,
  input  wire logic                    fw_ack,
  input  wire logic                    fw_err,
  input  wire logic [psm_pkg::DW-1:0]  fw_rdata,
  input  wire logic                    upd_image_ok,
  input  wire logic [psm_pkg::DW-1:0]  upd_version,
  input  wire logic [psm_pkg::AW-1:0]  cfg_addr,
  output logic      [psm_pkg::DW-1:0]  cfg_data,
  output logic                         boot_from_update,
  output logic                         params_ready
);

  psm_pkg::psm_ctl_t     s_r;
  psm_pkg::psm_ctl_t     s_nxt;
  psm_pkg::psm_status_t  grd_status;
  logic                  unlocked;
  logic                  take;
  logic                  wc_we;
  logic [psm_pkg::AW-1:0] wc_addr;
  logic [psm_pkg::DW-1:0] wc_wdata;
  logic [psm_pkg::DW-1:0] wc_rdata;

  // ----------------------------------------------------------------
  // working copy and access guard
  // ----------------------------------------------------------------
  // port b is the only path internal functions use for configuration
  psm_wcopy_ram u_wcopy (
    .clk     (clk),
    .a_we    (wc_we),
    .a_addr  (wc_addr),
    .a_wdata (wc_wdata),
    .a_rdata (wc_rdata),
    .b_addr  (cfg_addr),
    .b_rdata (cfg_data)
  );

  psm_fw_guard u_guard (
    .clk      (clk),
    .rstn     (rstn),
    .take     (take),
    .req      (req),
    .status   (grd_status),
    .unlocked (unlocked)
  );

  // ----------------------------------------------------------------
  // host handshake
  // ----------------------------------------------------------------
  // one request port serves every host interface, so all see the same checks
  assign req_ready = (s_r.st == psm_pkg::S_IDLE);
  assign take      = req_valid && req_ready;

  assign rsp_valid        = s_r.rsp_v;
  assign rsp              = s_r.rsp;
  assign nv_req           = s_r.nv_req;
  assign nv_cmd           = s_r.nv;
  assign fw_req           = s_r.fw_req;
  assign fw_cmd           = s_r.fw;
  assign boot_from_update = s_r.boot_upd;
  assign params_ready     = s_r.ready;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.rsp_v    = 1'b0;
    wc_we          = 1'b0;
    wc_addr        = s_r.idx;
    wc_wdata       = nv_rdata;
    case (s_r.st)
      psm_pkg::S_BOOT: begin
        // update image first, golden when it will not boot
        s_nxt.boot_upd = upd_image_ok;
        s_nxt.idx      = '0;
        s_nxt.ph       = 1'b0;
        s_nxt.host_op  = 1'b0;
        s_nxt.sel      = psm_pkg::SET_USER;
        if (default_recovery_input) begin
          s_nxt.st = psm_pkg::S_RECOV;
        end else begin
          s_nxt.st = psm_pkg::S_LOAD;
        end
      end
      psm_pkg::S_RECOV: begin
        // read default entry, then write it to the user set at the same index
        if (!s_r.nv_req && !s_r.ph) begin
          s_nxt.nv_req = 1'b1;
          s_nxt.nv     = '{we: 1'b0, sel: psm_pkg::SET_DEFAULT, addr: s_r.idx, wdata: '0};
        end else if (nv_ack && !s_r.ph) begin
          s_nxt.ph       = 1'b1;
          s_nxt.nv.we    = 1'b1;
          s_nxt.nv.sel   = psm_pkg::SET_USER;
          s_nxt.nv.wdata = nv_rdata;
        end else if (nv_ack) begin
          s_nxt.nv_req = 1'b0;
          s_nxt.ph     = 1'b0;
          s_nxt.idx    = s_r.idx + 8'h01;
          if (s_r.idx == psm_pkg::LAST_IDX) begin
            s_nxt.st  = psm_pkg::S_LOAD;
            s_nxt.sel = psm_pkg::SET_USER;
          end
        end
      end
      psm_pkg::S_LOAD: begin
        if (!s_r.nv_req) begin
          s_nxt.nv_req = 1'b1;
          s_nxt.nv     = '{we: 1'b0, sel: s_r.sel, addr: s_r.idx, wdata: '0};
        end else if (nv_ack) begin
          // every entry is overwritten, none survives from before
          wc_we        = 1'b1;
          s_nxt.nv_req = 1'b0;
          s_nxt.idx    = s_r.idx + 8'h01;
          if (s_r.idx == psm_pkg::LAST_IDX) begin
            s_nxt.st    = psm_pkg::S_IDLE;
            s_nxt.ready = 1'b1;
            s_nxt.rsp_v = s_r.host_op;
            s_nxt.rsp   = '{status: psm_pkg::ST_OK, data: '0};
          end
        end
      end
      psm_pkg::S_SAVE: begin
        // phase 0 addresses the copy, phase 1 sees its registered data
        if (!s_r.ph) begin
          s_nxt.ph = 1'b1;
        end else if (!s_r.nv_req) begin
          s_nxt.nv_req = 1'b1;
          s_nxt.nv     = '{we: 1'b1, sel: psm_pkg::SET_USER, addr: s_r.idx, wdata: wc_rdata};
        end else if (nv_ack) begin
          s_nxt.nv_req = 1'b0;
          s_nxt.ph     = 1'b0;
          s_nxt.idx    = s_r.idx + 8'h01;
          if (s_r.idx == psm_pkg::LAST_IDX) begin
            s_nxt.st    = psm_pkg::S_IDLE;
            s_nxt.rsp_v = 1'b1;
            s_nxt.rsp   = '{status: psm_pkg::ST_OK, data: '0};
          end
        end
      end
      psm_pkg::S_RD: begin
        s_nxt.st    = psm_pkg::S_IDLE;
        s_nxt.rsp_v = 1'b1;
        s_nxt.rsp   = '{status: psm_pkg::ST_OK, data: wc_rdata};
      end
      psm_pkg::S_FW: begin
        if (fw_ack) begin
          s_nxt.fw_req     = 1'b0;
          s_nxt.st         = psm_pkg::S_IDLE;
          s_nxt.rsp_v      = 1'b1;
          s_nxt.rsp.data   = fw_rdata;
          s_nxt.rsp.status = fw_err ? psm_pkg::ST_ERR_FW : psm_pkg::ST_OK;
        end
      end
      default: begin
        wc_addr  = req.idx;
        wc_wdata = req.data;
        if (take) begin
          s_nxt.rsp = '{status: grd_status, data: '0};
          if (grd_status != psm_pkg::ST_OK) begin
            // refused: stores untouched, error code back at once
            s_nxt.rsp_v = 1'b1;
          end else begin
            case (req.op)
              psm_pkg::OP_RD: begin
                s_nxt.st = psm_pkg::S_RD;
              end
              psm_pkg::OP_WR: begin
                wc_we       = 1'b1;
                s_nxt.rsp_v = 1'b1;
              end
              psm_pkg::OP_LOAD: begin
                s_nxt.st      = psm_pkg::S_LOAD;
                s_nxt.sel     = req.sel;
                s_nxt.idx     = '0;
                s_nxt.host_op = 1'b1;
              end
              psm_pkg::OP_SAVE: begin
                s_nxt.st  = psm_pkg::S_SAVE;
                s_nxt.idx = '0;
                s_nxt.ph  = 1'b0;
              end
              psm_pkg::OP_FW_WR, psm_pkg::OP_FW_RD, psm_pkg::OP_FW_DEL: begin
                // only the update area is reachable from this port
                s_nxt.st       = psm_pkg::S_FW;
                s_nxt.fw_req   = 1'b1;
                s_nxt.fw.sect  = req.idx;
                s_nxt.fw.wdata = req.data;
                s_nxt.fw.op    = (req.op == psm_pkg::OP_FW_WR) ? psm_pkg::FW_WRITE :
                                 (req.op == psm_pkg::OP_FW_RD) ? psm_pkg::FW_READ : psm_pkg::FW_ERASE;
              end
              psm_pkg::OP_VER: begin
                s_nxt.rsp_v    = 1'b1;
                s_nxt.rsp.data = s_r.boot_upd ? upd_version : psm_pkg::GOLDEN_VERSION;
              end
              default: begin
                s_nxt.rsp_v = 1'b1;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence take_op(psm_pkg::psm_op_t o);
    take && req.op == o;
  endsequence

  sequence refused_prot;
    rsp_valid && rsp.status == psm_pkg::ST_ERR_PROT && !nv_req && !fw_req;
  endsequence

  property busy_blocks_p;
    (nv_req || fw_req || !params_ready) |-> !req_ready;
  endproperty

  busy_hold_a: assert property (busy_blocks_p)
    else $error("request accepted during a transfer");

  save_refuse_a: assert property (take_op(psm_pkg::OP_SAVE) and (req.sel == psm_pkg::SET_DEFAULT) |=> refused_prot)
    else $error("save to default set not refused");

  default_nowrite_a: assert property (nv_req && nv_cmd.we |-> nv_cmd.sel == psm_pkg::SET_USER)
    else $error("write aimed at default set");

  golden_guard_a: assert property (take && req.op inside {psm_pkg::OP_FW_WR, psm_pkg::OP_FW_DEL}
                                   && req.sel == psm_pkg::AREA_GOLDEN |=> refused_prot)
    else $error("golden area command not refused");

  delete_lock_a: assert property (take_op(psm_pkg::OP_FW_DEL) and (req.sel == psm_pkg::AREA_UPDATE) and !unlocked
                                  |=> rsp_valid && rsp.status == psm_pkg::ST_ERR_LOCK && !fw_req)
    else $error("locked delete not rejected");

  load_write_a: assert property (s_r.st == psm_pkg::S_LOAD && nv_req && nv_ack
                                 |-> wc_we && wc_addr == nv_cmd.addr && wc_wdata == nv_rdata)
    else $error("loaded word not written to working copy");

  read_answer_a: assert property (take_op(psm_pkg::OP_RD) and (grd_status == psm_pkg::ST_OK)
                                  |=> !rsp_valid ##1 rsp_valid)
    else $error("parameter read answer not two cycles later");

  boot_user_a: assert property ($rose(params_ready) |-> $past(s_r.st) == psm_pkg::S_LOAD
                                && $past(s_r.sel) == psm_pkg::SET_USER && !$past(s_r.host_op))
    else $error("first ready not after a user set load");

  recov_read_a: assert property (s_r.st == psm_pkg::S_RECOV && nv_req && !nv_cmd.we
                                 |-> nv_cmd.sel == psm_pkg::SET_DEFAULT)
    else $error("recovery reads the wrong set");

  image_pick_a: assert property (s_r.st == psm_pkg::S_BOOT |=> boot_from_update == $past(upd_image_ok))
    else $error("boot image choice wrong");

endmodule
`default_nettype wire

/* File: common/psm_pkg.sv */
// shared constants and types for the parameter set manager
package psm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NPARAM = 256;
  localparam int unsigned AW     = 8;
  localparam int unsigned DW     = 16;
  localparam logic [AW-1:0] LAST_IDX = 8'hFF;

  // ----------------------------------------------------------------
  // set and area selectors, versions, codes
  // ----------------------------------------------------------------
  localparam logic SET_DEFAULT  = 1'h0;
  localparam logic SET_USER     = 1'h1;
  localparam logic AREA_GOLDEN  = 1'h0;
  localparam logic AREA_UPDATE  = 1'h1;
  localparam logic [DW-1:0] GOLDEN_VERSION = 16'h0100; // arbitrary value
  localparam logic [DW-1:0] SERVICE_CODE   = 16'h5A3C; // arbitrary value

  // ----------------------------------------------------------------
  // host operations, answers, firmware commands, states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_RD, OP_WR, OP_LOAD, OP_SAVE, OP_FW_WR, OP_FW_RD, OP_FW_DEL, OP_UNLOCK, OP_VER
  } psm_op_t;

  typedef enum logic [1:0] {ST_OK, ST_ERR_PROT, ST_ERR_LOCK, ST_ERR_FW} psm_status_t;

  typedef enum logic [1:0] {FW_WRITE, FW_READ, FW_ERASE} psm_fw_op_t;

  typedef enum logic [2:0] {S_BOOT, S_RECOV, S_LOAD, S_SAVE, S_RD, S_FW, S_IDLE} psm_state_t;

  typedef struct packed {
    psm_op_t       op;
    logic          sel;   // set index for load/save, area for firmware ops
    logic [AW-1:0] idx;   // parameter index or firmware section
    logic [DW-1:0] data;
  } psm_req_t;

  typedef struct packed {
    psm_status_t   status;
    logic [DW-1:0] data;
  } psm_rsp_t;

  typedef struct packed {
    logic          we;
    logic          sel;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } psm_nv_cmd_t;

  typedef struct packed {
    psm_fw_op_t    op;
    logic [AW-1:0] sect;
    logic [DW-1:0] wdata;
  } psm_fw_cmd_t;

  typedef struct packed {
    psm_state_t    st;
    logic          ph;
    logic [AW-1:0] idx;
    logic          sel;
    logic          host_op;
    logic          ready;
    logic          boot_upd;
    logic          rsp_v;
    psm_rsp_t      rsp;
    logic          nv_req;
    psm_nv_cmd_t   nv;
    logic          fw_req;
    psm_fw_cmd_t   fw;
  } psm_ctl_t;

endpackage

/* File: rtl/psm_wcopy_ram.sv */
// working copy of the parameter set: one read/write port, one config read port
`timescale 1ns/1ps
`default_nettype none
module psm_wcopy_ram (
  input  wire logic                    clk,
  input  wire logic                    a_we,
  input  wire logic [psm_pkg::AW-1:0]  a_addr,
  input  wire logic [psm_pkg::DW-1:0]  a_wdata,
  output logic      [psm_pkg::DW-1:0]  a_rdata,
  input  wire logic [psm_pkg::AW-1:0]  b_addr,
  output logic      [psm_pkg::DW-1:0]  b_rdata
);

  typedef struct packed {
    logic [psm_pkg::DW-1:0] a;
    logic [psm_pkg::DW-1:0] b;
  } psm_ram_q_t;

  logic [psm_pkg::DW-1:0] mem [psm_pkg::NPARAM];
  psm_ram_q_t             q_r;
  psm_ram_q_t             q_nxt;

  // ----------------------------------------------------------------
  // storage: volatile, contents undefined until the boot load fills it
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt.a = mem[a_addr];
    q_nxt.b = mem[b_addr];
  end

  // no reset on the array so it maps onto block memory
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    q_r <= q_nxt;
  end

  assign a_rdata = q_r.a;
  assign b_rdata = q_r.b;

endmodule
`default_nettype wire

/* File: rtl/psm_fw_guard.sv */
// access checks for protected stores and the service unlock flag
`timescale 1ns/1ps
`default_nettype none
module psm_fw_guard (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              take,
  input  wire psm_pkg::psm_req_t req,
  output psm_pkg::psm_status_t   status,
  output logic                   unlocked
);

  typedef struct packed {
    logic unlocked;
  } psm_grd_t;

  psm_grd_t s_r;
  psm_grd_t s_nxt;

  // ----------------------------------------------------------------
  // decision for one request
  // ----------------------------------------------------------------
  function automatic psm_pkg::psm_status_t check(psm_pkg::psm_req_t r, logic unl);
    check = psm_pkg::ST_OK;
    case (r.op)
      psm_pkg::OP_SAVE: begin
        if (r.sel == psm_pkg::SET_DEFAULT) check = psm_pkg::ST_ERR_PROT;
      end
      psm_pkg::OP_FW_WR, psm_pkg::OP_FW_RD: begin
        if (r.sel == psm_pkg::AREA_GOLDEN) check = psm_pkg::ST_ERR_PROT;
      end
      psm_pkg::OP_FW_DEL: begin
        if (r.sel == psm_pkg::AREA_GOLDEN) check = psm_pkg::ST_ERR_PROT;
        else if (!unl) check = psm_pkg::ST_ERR_LOCK;
      end
      psm_pkg::OP_UNLOCK: begin
        if (r.data != psm_pkg::SERVICE_CODE) check = psm_pkg::ST_ERR_LOCK;
      end
      default: check = psm_pkg::ST_OK;
    endcase
  endfunction

  assign status   = check(req, s_r.unlocked);
  assign unlocked = s_r.unlocked;

  // a wrong code locks again, so a stray write cannot leave delete open
  always_comb begin
    s_nxt = s_r;
    if (take && req.op == psm_pkg::OP_UNLOCK) begin
      s_nxt.unlocked = (req.data == psm_pkg::SERVICE_CODE);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: bench/psm_store_model.sv */
// far-side model: non-volatile parameter sets and firmware update area
`timescale 1ns/1ps
`default_nettype none
module psm_store_model (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 slow,
  input  wire logic                 fw_fail,
  input  wire logic                 nv_req,
  input  wire psm_pkg::psm_nv_cmd_t nv_cmd,
  output logic                      nv_ack,
  output logic [psm_pkg::DW-1:0]    nv_rdata,
  input  wire logic                 fw_req,
  input  wire psm_pkg::psm_fw_cmd_t fw_cmd,
  output logic                      fw_ack,
  output logic                      fw_err,
  output logic [psm_pkg::DW-1:0]    fw_rdata
);
  logic [15:0] nv_mem [2][256];
  logic [15:0] upd_mem [256];
  logic [1:0]  nv_cnt;
  // factory contents: set 0 default, set 1 user, update area blank
  initial begin
    for (int i = 0; i < 256; i++) begin
      nv_mem[0][i] = {8'hD0, i[7:0]};
      nv_mem[1][i] = {8'h5E, i[7:0]};
      upd_mem[i] = 16'hFFFF;
    end
  end
  // one ack per request; slow stretches latency; set 0 is not guarded here, a stray write shows up
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_ack <= 1'b0;
      nv_cnt <= 2'h0;
      nv_rdata <= 16'hA5A5;
    end else if (nv_req && !nv_ack && nv_cnt == {slow, slow}) begin
      nv_ack <= 1'b1;
      nv_cnt <= 2'h0;
      nv_rdata <= nv_mem[nv_cmd.sel][nv_cmd.addr];
      if (nv_cmd.we) nv_mem[nv_cmd.sel][nv_cmd.addr] <= nv_cmd.wdata;
    end else begin
      nv_ack <= 1'b0;
      nv_rdata <= ~nv_rdata; // released data must not look valid
      if (nv_req && !nv_ack) nv_cnt <= nv_cnt + 2'h1;
    end
  end
  // firmware store answers one cycle after a fresh request
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fw_ack <= 1'b0;
      fw_err <= 1'b0;
      fw_rdata <= 16'h5A5A;
    end else if (fw_req && !fw_ack) begin
      fw_ack <= 1'b1;
      fw_err <= fw_fail;
      case (fw_cmd.op)
        psm_pkg::FW_WRITE: upd_mem[fw_cmd.sect] <= fw_cmd.wdata;
        psm_pkg::FW_READ:  fw_rdata <= upd_mem[fw_cmd.sect];
        default: for (int i = 0; i < 256; i++) upd_mem[i] <= 16'hFFFF;
      endcase
    end else begin
      fw_ack <= 1'b0;
      fw_err <= ~fw_err;
      fw_rdata <= ~fw_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: bench/psm_param_set_mgr_test.sv */
// self-checking testbench for the parameter set manager
`timescale 1ns/1ps
`default_nettype none
module psm_param_set_mgr_test;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 rec_in = 1'b0;
  logic                 img_ok = 1'b1;
  logic                 slow = 1'b0;
  logic                 fw_fail = 1'b0;
  logic                 req_valid = 1'b0;
  psm_pkg::psm_req_t    req = '0;
  logic [7:0]           cfg_addr = 8'h00;
  logic [15:0]          upd_ver = 16'h0207;
  logic                 req_ready, rsp_valid, nv_req, nv_ack, fw_req, fw_ack, fw_err;
  logic                 boot_from_update, params_ready;
  psm_pkg::psm_rsp_t    rsp;
  psm_pkg::psm_nv_cmd_t nv_cmd;
  psm_pkg::psm_fw_cmd_t fw_cmd;
  logic [15:0]          nv_rdata, fw_rdata, cfg_data, rsp_d;
  logic [1:0]           rsp_st;
  int                   error_cnt = 0;
  int                   n_compared = 0;
  int                   wait_n, cyc = 0;

  always #5 clk = ~clk;

  psm_param_set_mgr dut_u (.clk(clk), .rstn(rstn), .default_recovery_input(rec_in), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .nv_req(nv_req), .nv_cmd(nv_cmd),
    .nv_ack(nv_ack), .nv_rdata(nv_rdata), .fw_req(fw_req), .fw_cmd(fw_cmd), .fw_ack(fw_ack), .fw_err(fw_err),
    .fw_rdata(fw_rdata), .upd_image_ok(img_ok), .upd_version(upd_ver), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .boot_from_update(boot_from_update), .params_ready(params_ready));

  psm_store_model store_u (.clk(clk), .rstn(rstn), .slow(slow), .fw_fail(fw_fail), .nv_req(nv_req),
    .nv_cmd(nv_cmd), .nv_ack(nv_ack), .nv_rdata(nv_rdata), .fw_req(fw_req), .fw_cmd(fw_cmd),
    .fw_ack(fw_ack), .fw_err(fw_err), .fw_rdata(fw_rdata));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // hang guard: whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end

  // one host request: held until taken, then wait for the answer pulse
  task automatic host(input psm_pkg::psm_op_t op, input logic s, input logic [7:0] i, input logic [15:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: op, sel: s, idx: i, data: d};
    #1;
    for (int n = 0; n < 5000 && !req_ready; n++) @(posedge clk) #1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    // a one-cycle answer already stands right after the take edge
    wait_n = 0;
    while (!rsp_valid && wait_n < 5000) begin
      @(posedge clk) #1;
      wait_n++;
    end
    chk({15'h0, rsp_valid}, 16'h0001);
    rsp_st = rsp.status;
    rsp_d = rsp.data;
  endtask

  // power-up with the recovery input and image state given
  task automatic boot(input logic rec, input logic ok);
    @(posedge clk);
    rstn <= 1'b0;
    rec_in <= rec;
    img_ok <= ok;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk) #1;
    chk({15'h0, req_ready}, 16'h0000);
    for (int n = 0; n < 20000 && !params_ready; n++) @(posedge clk) #1;
    rec_in <= 1'b0;
    chk({15'h0, params_ready}, 16'h0001);
  endtask

  // sweep the config port; set 1 patterns unless s is 0
  task automatic cfg_chk(input logic s);
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      cfg_addr <= i[7:0];
      @(posedge clk) #1;
      chk(cfg_data, {s ? 8'h5E : 8'hD0, i[7:0]});
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    boot(1'b0, 1'b1);
    chk({15'h0, boot_from_update}, 16'h0001);
    cfg_chk(1'b1);
    host(psm_pkg::OP_VER, 1'b0, 8'h00, 16'h0000);
    chk(rsp_d, 16'h0207);
  endtask

  task automatic t_rw();
    host(psm_pkg::OP_WR, 1'b0, 8'hFF, 16'hBEEF);
    chk({14'h0, rsp_st}, 16'h0000);
    host(psm_pkg::OP_RD, 1'b0, 8'hFF, 16'h0000);
    chk(rsp_d, 16'hBEEF);
  endtask

  // slow store: the request stays out until every word is through
  task automatic t_save();
    slow <= 1'b1;
    host(psm_pkg::OP_SAVE, 1'b1, 8'h00, 16'h0000);
    slow <= 1'b0;
    chk({14'h0, rsp_st}, 16'h0000);
    chk(store_u.nv_mem[1][255], 16'hBEEF);
    chk(store_u.nv_mem[1][1], 16'h5E01);
    chk(16'(wait_n >= 256), 16'h0001);
  endtask

  task automatic t_refuse();
    psm_pkg::psm_op_t ops [5] = '{psm_pkg::OP_SAVE, psm_pkg::OP_FW_WR, psm_pkg::OP_FW_RD,
                                  psm_pkg::OP_FW_DEL, psm_pkg::OP_UNLOCK};
    logic [1:0]       exp [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
    for (int k = 0; k < 5; k++) begin
      host(ops[k], k == 3, 8'h03, 16'h0000);
      chk({14'h0, rsp_st}, {14'h0, exp[k]});
    end
    chk(store_u.nv_mem[0][255], 16'hD0FF);
  endtask

  task automatic t_load();
    host(psm_pkg::OP_LOAD, 1'b0, 8'h00, 16'h0000);
    chk({14'h0, rsp_st}, 16'h0000);
    cfg_chk(1'b0);
    host(psm_pkg::OP_LOAD, 1'b1, 8'h00, 16'h0000);
    host(psm_pkg::OP_RD, 1'b0, 8'hFF, 16'h0000);
    chk(rsp_d, 16'hBEEF);
  endtask

  task automatic t_fw();
    host(psm_pkg::OP_UNLOCK, 1'b0, 8'h00, psm_pkg::SERVICE_CODE);
    chk({14'h0, rsp_st}, 16'h0000);
    host(psm_pkg::OP_FW_WR, 1'b1, 8'h03, 16'h1234);
    chk(store_u.upd_mem[3], 16'h1234);
    host(psm_pkg::OP_FW_RD, 1'b1, 8'h03, 16'h0000);
    chk(rsp_d, 16'h1234);
    fw_fail <= 1'b1;
    host(psm_pkg::OP_FW_RD, 1'b1, 8'h03, 16'h0000);
    fw_fail <= 1'b0;
    chk({14'h0, rsp_st}, 16'h0003);
    host(psm_pkg::OP_FW_DEL, 1'b1, 8'h00, 16'h0000);
    chk({14'h0, rsp_st}, 16'h0000);
    chk(store_u.upd_mem[3], 16'hFFFF);
  endtask

  // recovery power-up with a broken update image
  task automatic t_recov();
    boot(1'b1, 1'b0);
    chk({15'h0, boot_from_update}, 16'h0000);
    for (int i = 0; i < 256; i++) chk(store_u.nv_mem[1][i], {8'hD0, i[7:0]});
    cfg_chk(1'b0);
    host(psm_pkg::OP_VER, 1'b0, 8'h00, 16'h0000);
    chk(rsp_d, psm_pkg::GOLDEN_VERSION);
  endtask

  initial begin
    t_boot();
    t_rw();
    t_save();
    t_refuse();
    t_load();
    t_fw();
    t_recov();
    end_sim();
  end
endmodule
`default_nettype wire
